/* shared/apil_pkg.sv */
// constants and types for the auxiliary pin and interrupt logic
// assumes an apb slave with 32-bit data and one word per register
package apil_pkg;

    // sizes
    localparam int APIL_NSTAGE = 12;
    localparam int APIL_RW = 16;
    localparam int APIL_AW = 12;

    // register indexes, byte address is four times the index
    localparam logic [9:0] APIL_IDX_LOW_EN = 10'h005;
    localparam logic [9:0] APIL_IDX_HIGH_EN = 10'h006;
    localparam logic [9:0] APIL_IDX_DONE_EN = 10'h007;
    localparam logic [9:0] APIL_IDX_LOW_FLAGS = 10'h008;
    localparam logic [9:0] APIL_IDX_HIGH_FLAGS = 10'h009;
    localparam logic [9:0] APIL_IDX_DONE_FLAGS = 10'h00a;

    // field positions
    localparam int APIL_PIN_SETUP_LSB = 12;
    localparam int APIL_PIN_SETUP_MSB = 13;
    localparam int APIL_TRIG_LSB = 14;
    localparam int APIL_TRIG_MSB = 15;
    localparam int APIL_PIN_EN_BIT = 12;
    localparam int APIL_PIN_STAT_BIT = 12;

    // reset values
    localparam logic [15:0] APIL_EN_RST = 16'h0000;
    localparam logic [11:0] APIL_FLAGS_RST = 12'h000;

    // pin setup codes
    typedef enum logic [1:0] {
        APIL_PIN_OFF = 2'h0,
        APIL_PIN_IN = 2'h1,
        APIL_PIN_OUT_LO = 2'h2,
        APIL_PIN_OUT_HI = 2'h3
    } apil_setup_t;

    // input trigger codes
    typedef enum logic [1:0] {
        APIL_TRIG_LVL_LO = 2'h0,
        APIL_TRIG_RISE = 2'h1,
        APIL_TRIG_FALL = 2'h2,
        APIL_TRIG_LVL_HI = 2'h3
    } apil_trig_t;

endpackage

/* rtl/apil_sync.sv */
// three-stage synchroniser with agreement filter for the aux pin
// assumes the pin is asynchronous to sys_clk
`timescale 1ns/100ps
module apil_sync (
    // clock and reset
    input wire logic sys_clk,
    input wire logic nrst,
    // pin side
    input wire logic pin_in,
    // filtered level
    output logic pin_f
);
    import apil_pkg::*;

    logic s1_r, s2_r, s3_r, filt_r;
    logic filt_nxt;

    always_comb begin
        filt_nxt = filt_r;
        if (s2_r == s3_r) begin
            filt_nxt = s3_r;
        end
    end

    // stage chain, first stage feeds only the second
    always_ff @(posedge sys_clk) begin
        if (!nrst) begin
            s1_r <= 1'b0;
            s2_r <= 1'b0;
            s3_r <= 1'b0;
            filt_r <= 1'b0;
        end else begin
            s1_r <= pin_in;
            s2_r <= s1_r;
            s3_r <= s2_r;
            filt_r <= filt_nxt;
        end
    end

    assign pin_f = filt_r;
endmodule

/* rtl/apil_trig.sv */
// trigger decode for the aux pin: level or edge of either polarity
// assumes pin_f is already synchronised to sys_clk
`timescale 1ns/100ps
module apil_trig (
    // clock and reset
    input wire logic sys_clk,
    input wire logic nrst,
    // synchronised pin and trigger select
    input wire logic pin_f,
    input wire apil_pkg::apil_trig_t trig,
    // decoded conditions
    output logic lvl_act,
    output logic edge_hit,
    output logic edge_mode
);
    import apil_pkg::*;

    logic prev_r;
    logic prev_nxt;

    always_comb begin
        prev_nxt = pin_f;
        lvl_act = 1'b0;
        edge_hit = 1'b0;
        edge_mode = 1'b0;
        unique case (trig)
            APIL_TRIG_LVL_LO: lvl_act = !pin_f;
            APIL_TRIG_RISE: begin
                edge_mode = 1'b1;
                edge_hit = pin_f && !prev_r;
            end
            APIL_TRIG_FALL: begin
                edge_mode = 1'b1;
                edge_hit = !pin_f && prev_r;
            end
            APIL_TRIG_LVL_HI: lvl_act = pin_f;
        endcase
    end

    // previous sample for edge compare
    always_ff @(posedge sys_clk) begin
        if (!nrst) begin
            prev_r <= 1'b0;
        end else begin
            prev_r <= prev_nxt;
        end
    end
endmodule

/* rtl/apil_top.sv */
// interrupt line and aux pin logic with an apb register slave
// assumes converter events come from sys_clk logic, aux pin is async
//
// The APB slave port was left to the implementer.
`timescale 1ns/100ps
module apil_top (
    // clock and reset
    input wire logic sys_clk,
    input wire logic nrst,
    // apb slave
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [apil_pkg::APIL_AW-1:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    // converter events
    input wire logic [apil_pkg::APIL_NSTAGE-1:0] stage_done,
    input wire logic [apil_pkg::APIL_NSTAGE-1:0] low_thr_active,
    input wire logic [apil_pkg::APIL_NSTAGE-1:0] high_thr_active,
    // aux pin
    input wire logic aux_pin_in,
    output logic aux_pin_out,
    output logic aux_pin_oe,
    // interrupt line, open drain active low
    output logic int_n_out,
    output logic int_n_oe,
    output logic irq
);
    import apil_pkg::*;

    localparam int NS = APIL_NSTAGE;

    // register state
    logic [APIL_RW-1:0] low_en_r, high_en_r, done_en_r;
    logic [APIL_RW-1:0] low_en_nxt, high_en_nxt, done_en_nxt;
    logic [NS-1:0] done_flags_r, done_flags_nxt;
    logic [NS-1:0] low_cur_r, low_cur_nxt, high_cur_r, high_cur_nxt;
    logic low_pend_r, low_pend_nxt, high_pend_r, high_pend_nxt;
    logic pin_stat_r, pin_stat_nxt;
    logic irq_r, irq_nxt;
    logic [31:0] rdata_r, rdata_nxt;

    // bus decode
    logic setup, access, rd_setup, wr_acc;
    logic [9:0] idx;
    logic hit;
    logic clr_low, clr_high, clr_done;
    logic [31:0] rd_mux;

    // converter and pin terms
    logic [NS-1:0] mlow, mhigh, done_set;
    logic pin_f, lvl_act, edge_hit, edge_mode, pin_armed;
    apil_setup_t pin_setup;
    apil_trig_t trig;

    // pin synchroniser and trigger decode
    apil_sync u_sync (
        .sys_clk(sys_clk),
        .nrst(nrst),
        .pin_in(aux_pin_in),
        .pin_f(pin_f)
    );

    apil_trig u_trig (
        .sys_clk(sys_clk),
        .nrst(nrst),
        .pin_f(pin_f),
        .trig(trig),
        .lvl_act(lvl_act),
        .edge_hit(edge_hit),
        .edge_mode(edge_mode)
    );

    // apb phases, slave is always ready
    assign setup = psel && !penable;
    assign access = psel && penable;
    assign rd_setup = setup && !pwrite;
    assign wr_acc = access && pwrite;
    assign idx = paddr[APIL_AW-1:2];
    assign pready = 1'b1;
    assign prdata = rdata_r;

    // address decode
    always_comb begin
        hit = 1'b1;
        rd_mux = 32'h0000_0000;
        unique case (idx)
            APIL_IDX_LOW_EN: rd_mux[APIL_RW-1:0] = low_en_r;
            APIL_IDX_HIGH_EN: rd_mux[APIL_RW-1:0] = high_en_r;
            APIL_IDX_DONE_EN: rd_mux[APIL_RW-1:0] = done_en_r;
            APIL_IDX_LOW_FLAGS: rd_mux[NS-1:0] = low_cur_r;
            APIL_IDX_HIGH_FLAGS: rd_mux[NS-1:0] = high_cur_r;
            APIL_IDX_DONE_FLAGS: begin
                rd_mux[NS-1:0] = done_flags_r;
                rd_mux[APIL_PIN_STAT_BIT] = pin_stat_r;
            end
            default: hit = 1'b0;
        endcase
    end

    // unmapped address answers with an error
    assign pslverr = access && !hit;

    assign clr_low = rd_setup && (idx == APIL_IDX_LOW_FLAGS);
    assign clr_high = rd_setup && (idx == APIL_IDX_HIGH_FLAGS);
    assign clr_done = rd_setup && (idx == APIL_IDX_DONE_FLAGS);

    // read data captured at setup, before the flags clear
    always_comb begin
        rdata_nxt = rdata_r;
        if (rd_setup) begin
            rdata_nxt = rd_mux;
        end
    end

    // enable registers, written in the access phase
    always_comb begin
        low_en_nxt = low_en_r;
        high_en_nxt = high_en_r;
        done_en_nxt = done_en_r;
        if (wr_acc && idx == APIL_IDX_LOW_EN) begin
            low_en_nxt = pwdata[APIL_RW-1:0];
        end
        if (wr_acc && idx == APIL_IDX_HIGH_EN) begin
            high_en_nxt = pwdata[APIL_RW-1:0];
        end
        if (wr_acc && idx == APIL_IDX_DONE_EN) begin
            done_en_nxt = pwdata[APIL_RW-1:0];
        end
    end

    assign pin_setup = apil_setup_t'(
        low_en_r[APIL_PIN_SETUP_MSB:APIL_PIN_SETUP_LSB]);
    assign trig = apil_trig_t'(low_en_r[APIL_TRIG_MSB:APIL_TRIG_LSB]);
    // msb of setup enables the driver, lsb gives the level
    assign aux_pin_oe = low_en_r[APIL_PIN_SETUP_MSB];
    assign aux_pin_out = low_en_r[APIL_PIN_SETUP_LSB];

    assign pin_armed = (pin_setup == APIL_PIN_IN)
        && done_en_r[APIL_PIN_EN_BIT];

    assign done_set = stage_done & done_en_r[NS-1:0];
    always_comb begin
        done_flags_nxt = done_set | (done_flags_r & ~{NS{clr_done}});
    end

    assign mlow = low_thr_active & low_en_r[NS-1:0];
    assign mhigh = high_thr_active & high_en_r[NS-1:0];
    always_comb begin
        low_cur_nxt = mlow;
        high_cur_nxt = mhigh;
        low_pend_nxt = (mlow != low_cur_r) || (low_pend_r && !clr_low);
        high_pend_nxt = (mhigh != high_cur_r)
            || (high_pend_r && !clr_high);
    end

    always_comb begin
        pin_stat_nxt = pin_armed && (lvl_act || edge_hit
            || (edge_mode && pin_stat_r && !clr_done));
    end

    always_comb begin
        irq_nxt = (|done_flags_nxt) || low_pend_nxt || high_pend_nxt
            || pin_stat_nxt;
    end
    assign int_n_out = 1'b0;
    assign int_n_oe = irq_r;
    assign irq = irq_r;

    // state registers
    always_ff @(posedge sys_clk) begin
        if (!nrst) begin
            low_en_r <= APIL_EN_RST;
            high_en_r <= APIL_EN_RST;
            done_en_r <= APIL_EN_RST;
            done_flags_r <= APIL_FLAGS_RST;
            low_cur_r <= APIL_FLAGS_RST;
            high_cur_r <= APIL_FLAGS_RST;
            low_pend_r <= 1'b0;
            high_pend_r <= 1'b0;
            pin_stat_r <= 1'b0;
            irq_r <= 1'b0;
            rdata_r <= 32'h0000_0000;
        end else begin
            low_en_r <= low_en_nxt;
            high_en_r <= high_en_nxt;
            done_en_r <= done_en_nxt;
            done_flags_r <= done_flags_nxt;
            low_cur_r <= low_cur_nxt;
            high_cur_r <= high_cur_nxt;
            low_pend_r <= low_pend_nxt;
            high_pend_r <= high_pend_nxt;
            pin_stat_r <= pin_stat_nxt;
            irq_r <= irq_nxt;
            rdata_r <= rdata_nxt;
        end
    end

    // checks on the interrupt paths
    default clocking cb @(posedge sys_clk);
    endclocking
    default disable iff (!nrst);

    property p_done_sets;
        (stage_done[0] && done_en_r[0]) |=> done_flags_r[0] && int_n_oe;
    endproperty
    a_done_sets: assert property (p_done_sets)
        else $error("enabled stage done did not raise line");

    property p_done_off;
        (!done_en_r[0] && !done_flags_r[0]) |=> !done_flags_r[0];
    endproperty
    a_done_off: assert property (p_done_off)
        else $error("disabled stage set its flag");

    property p_done_clr;
        (clr_done && stage_done == '0) |=> done_flags_r == '0;
    endproperty
    a_done_clr: assert property (p_done_clr)
        else $error("completion flags kept after read setup");

    property p_thr_change;
        (mlow != low_cur_r) |=> low_pend_r && irq ##1 low_cur_r == $past(mlow);
    endproperty
    a_thr_change: assert property (p_thr_change)
        else $error("threshold change did not raise line");

    property p_thr_clr;
        (clr_low && mlow == low_cur_r) |=> !low_pend_r;
    endproperty
    a_thr_clr: assert property (p_thr_clr)
        else $error("low threshold pending kept after read");

    property p_pin_mode;
        (pin_setup != APIL_PIN_IN) |=> !pin_stat_r;
    endproperty
    a_pin_mode: assert property (p_pin_mode)
        else $error("pin status set outside input mode");

    property p_pin_en;
        !done_en_r[APIL_PIN_EN_BIT] |=> !pin_stat_r;
    endproperty
    a_pin_en: assert property (p_pin_en)
        else $error("pin status set while pin irq disabled");

    property p_pin_level;
        (pin_armed && lvl_act) |=> pin_stat_r && int_n_oe;
    endproperty
    a_pin_level: assert property (p_pin_level)
        else $error("level trigger did not hold line");

    property p_pin_edge;
        (pin_armed && edge_hit) |=> pin_stat_r && irq;
    endproperty
    a_pin_edge: assert property (p_pin_edge)
        else $error("edge trigger did not raise line");

    property p_pin_rdclr;
        (edge_mode && pin_stat_r && clr_done && !edge_hit) |=> !pin_stat_r;
    endproperty
    a_pin_rdclr: assert property (p_pin_rdclr)
        else $error("pin status not cleared by read");

    property p_pin_drive;
        (wr_acc && idx == APIL_IDX_LOW_EN
            && pwdata[APIL_PIN_SETUP_MSB:APIL_PIN_SETUP_LSB] == 2'h2)
            |=> aux_pin_oe && !aux_pin_out;
    endproperty
    a_pin_drive: assert property (p_pin_drive)
        else $error("drive low setup not applied");

    c_done_irq: cover property (stage_done[0] && done_en_r[0] ##1 irq);
    c_pin_edge: cover property (pin_armed && edge_hit ##1 clr_done);
    c_thr_irq: cover property ((mlow != low_cur_r) ##1 low_pend_r);
endmodule

/* tb/apil_host_model.sv */
// far side of the block: pull-up on the interrupt line, aux pin wire
// assumes the bench supplies the level an outside source puts on the pin
`timescale 1ns/100ps
module apil_host_model (
    // open drain interrupt line
    input wire logic int_n_out,
    input wire logic int_n_oe,
    output logic int_line,
    // aux pin
    input wire logic aux_pin_out,
    input wire logic aux_pin_oe,
    input wire logic ext_level,
    output logic aux_wire
);
    // pull-up wins while the block lets go of the line
    assign int_line = int_n_oe ? int_n_out : 1'b1;
    // the block's driver overrides the outside source
    assign aux_wire = aux_pin_oe ? aux_pin_out : ext_level;
endmodule

/* tb/apil_top_test.sv */
// self-checking bench for the aux pin and interrupt logic
// assumes zero wait apb slave and the host model on the pins
`timescale 1ns/100ps
module apil_top_test;
    import apil_pkg::*;
    logic sys_clk = 1'b0, nrst = 1'b0;
    logic psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
    logic [11:0] paddr = 12'h000;
    logic [31:0] pwdata = 32'h0, prdata, rd;
    logic pready, pslverr, err, aux_pin_out, aux_pin_oe;
    logic [11:0] stage_done = 12'h000, low_thr = 12'h000, high_thr = 12'h000;
    logic ext_level = 1'b1, aux_wire, int_n_out, int_n_oe, irq, int_line;
    int num_errors = 0, checked = 0;
    localparam logic [11:0] AD_LOW = {APIL_IDX_LOW_EN, 2'b00};
    localparam logic [11:0] AD_HIGH = {APIL_IDX_HIGH_EN, 2'b00};
    localparam logic [11:0] AD_DEN = {APIL_IDX_DONE_EN, 2'b00};
    localparam logic [11:0] AD_LFL = {APIL_IDX_LOW_FLAGS, 2'b00};
    localparam logic [11:0] AD_HFL = {APIL_IDX_HIGH_FLAGS, 2'b00};
    localparam logic [11:0] AD_DFL = {APIL_IDX_DONE_FLAGS, 2'b00};

    // clock at 10 MHz
    always #50 sys_clk = ~sys_clk;

    apil_top i_dut (.sys_clk(sys_clk), .nrst(nrst), .psel(psel),
        .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
        .prdata(prdata), .pready(pready), .pslverr(pslverr),
        .stage_done(stage_done), .low_thr_active(low_thr),
        .high_thr_active(high_thr), .aux_pin_in(aux_wire),
        .aux_pin_out(aux_pin_out), .aux_pin_oe(aux_pin_oe),
        .int_n_out(int_n_out), .int_n_oe(int_n_oe), .irq(irq));

    apil_host_model i_host (.int_n_out(int_n_out), .int_n_oe(int_n_oe),
        .int_line(int_line), .aux_pin_out(aux_pin_out),
        .aux_pin_oe(aux_pin_oe), .ext_level(ext_level),
        .aux_wire(aux_wire));

    task chk(input logic [31:0] seen, input logic [31:0] exp);
        checked++;
        if (seen !== exp) begin
            num_errors++;
            $display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask

    task cyc(input int n);
        repeat (n) @(posedge sys_clk);
    endtask

    // one apb transfer, held until pready is seen high
    task apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
        @(posedge sys_clk);
        psel <= 1'b1;
        pwrite <= wr;
        paddr <= a;
        pwdata <= d;
        @(posedge sys_clk);
        penable <= 1'b1;
        // wait for pready; only the watchdog ends a hang
        do begin
            @(posedge sys_clk);
        end while (pready !== 1'b1);
        rd = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask

    task t_regs;
        apb(0, AD_LOW, 0);
        chk(rd, 32'h0);
        chk(err, 1'b0);
        apb(0, AD_DEN, 0);
        chk(rd, 32'h0);
        apb(1, AD_HIGH, 32'hffff_1234);
        apb(0, AD_HIGH, 0);
        chk(rd, 32'h0000_1234);
        apb(1, AD_DFL, 32'hffff_ffff);
        apb(0, AD_DFL, 0);
        chk(rd, 32'h0);
        apb(0, 12'h3fc, 0);
        chk(err, 1'b1);
        $display("test done: registers");
    endtask

    task t_done;
        apb(1, AD_DEN, 32'h0221);
        @(posedge sys_clk) stage_done <= 12'hfff;
        @(posedge sys_clk) stage_done <= 12'h000;
        cyc(2);
        chk(irq, 1'b1);
        chk(int_line, 1'b0);
        apb(0, AD_DFL, 0);
        chk(rd, 32'h0221);
        chk(irq, 1'b0);
        cyc(1);
        chk(irq, 1'b0);
        chk(int_line, 1'b1);
        apb(1, AD_DEN, 0);
        @(posedge sys_clk) stage_done <= 12'hfff;
        @(posedge sys_clk) stage_done <= 12'h000;
        cyc(3);
        chk(irq, 1'b0);
        $display("test done: conversion complete");
    endtask

    task t_thr;
        apb(1, AD_LOW, 32'h0001);
        @(posedge sys_clk) low_thr <= 12'h041;
        cyc(3);
        chk(irq, 1'b1);
        apb(0, AD_LFL, 0);
        chk(rd, 32'h0001);
        cyc(1);
        chk(irq, 1'b0);
        @(posedge sys_clk) low_thr <= 12'h000;
        cyc(3);
        chk(irq, 1'b1);
        apb(0, AD_LFL, 0);
        chk(rd, 32'h0);
        cyc(1);
        chk(irq, 1'b0);
        // high threshold side: contact start and end on stage 1
        apb(1, AD_HIGH, 32'h0002);
        @(posedge sys_clk) high_thr <= 12'h006;
        cyc(3);
        chk(irq, 1'b1);
        apb(0, AD_HFL, 0);
        chk(rd, 32'h0002);
        cyc(1);
        chk(irq, 1'b0);
        @(posedge sys_clk) high_thr <= 12'h000;
        cyc(3);
        chk(irq, 1'b1);
        apb(0, AD_HFL, 0);
        chk(rd, 32'h0);
        cyc(1);
        chk(irq, 1'b0);
        $display("test done: threshold");
    endtask

    // pin setup codes with a low level trigger and the pin held low
    task t_setup;
        logic [1:0] s;
        apb(1, AD_DEN, 32'h1000);
        @(posedge sys_clk) ext_level <= 1'b0;
        for (int i = 0; i < 4; i++) begin
            s = 2'(i);
            apb(1, AD_LOW, {18'h0, s, 12'h000});
            cyc(10);
            apb(0, AD_DFL, 0);
            cyc(3);
            chk(aux_pin_oe, s[1]);
            chk(aux_wire, s[1] ? s[0] : 1'b0);
            chk(irq, s == 2'b01);
        end
        apb(1, AD_LOW, 32'h1000);
        apb(1, AD_DEN, 32'h0);
        apb(0, AD_DFL, 0);
        cyc(3);
        chk(irq, 1'b0);
        apb(1, AD_DEN, 32'h1000);
        cyc(3);
        chk(irq, 1'b1);
        $display("test done: pin setup");
    endtask

    // one trigger code: active level is bit 0 of the code
    task pin_case(input apil_trig_t t);
        logic lvl;
        lvl = (t == APIL_TRIG_LVL_LO) || (t == APIL_TRIG_LVL_HI);
        @(posedge sys_clk) ext_level <= ~t[0];
        apb(1, AD_LOW, {16'h0, t, APIL_PIN_IN, 12'h000});
        cyc(10);
        apb(0, AD_DFL, 0);
        cyc(2);
        @(posedge sys_clk) ext_level <= t[0];
        cyc(10);
        chk(irq, 1'b1);
        chk(int_line, 1'b0);
        apb(0, AD_DFL, 0);
        chk(rd, 32'h1000);
        cyc(1);
        chk(irq, lvl);
        @(posedge sys_clk) ext_level <= ~t[0];
        cyc(10);
        chk(irq, 1'b0);
        apb(0, AD_DFL, 0);
        chk(rd, 32'h0);
        $display("test done: trigger %0d", t);
    endtask

    task give_verdict;
        $display("errors %0d checks %0d", num_errors, checked);
        if (num_errors == 0 && checked > 0)
            $display("RESULT: PASS");
        else
            $display("RESULT: FAIL");
        $finish;
    endtask

    // watchdog far beyond the expected run
    initial begin
        cyc(20000);
        num_errors++;
        give_verdict();
    end

    // main sequence
    initial begin
        cyc(16);
        nrst <= 1'b1;
        t_regs();
        t_done();
        t_thr();
        t_setup();
        for (int i = 0; i < 4; i++) begin
            pin_case(apil_trig_t'(i));
        end
        give_verdict();
    end
endmodule
